// >>> hdl/mosr_regs.svh
// constants of the media capability and media control/status bank
// assumes a 25 MHz register clock and a byte-addressed bus of 32-bit words
//
// What this block does
// - read-only 16-bit capability register, window three
// - reset clears capability, then loads config word
// - unsupported media flags always read zero
// - internal tx phy flag zero when external
// - fx phy and 10 Mb/s twisted-pair flags
// - external phy flag; t4 flag left unsupported
// - mixed 16-bit control/status register, window four
// - keep received fcs in data; reset clears
// - sqe counter counts only while enabled
// - collision and carrier bits track live signals
// - babble guard stops transmit, fixes 10 Mb/s rx polarity
// - link pulse requirement gates transmission
// - long transmit trips flag, blocks until reset
// - inverted rx pair reported; fixed under guard at 10 Mb/s, not mii
// - link bit follows mode-specific link source
// - link bit forced one without gating, mii
// - sending bit shows frame transmission live
// - bit fifteen reads one, fourteen zero
`ifndef MOSR_REGS_SVH
`define MOSR_REGS_SVH
// ====================================================================
// address map: printed offsets are word indices
`define MOSR_CAP_INDEX 6'h08
`define MOSR_STATUS_INDEX 6'h0a
`define MOSR_WINSEL_INDEX 6'h00
`define MOSR_CMD_INDEX 6'h01
`define MOSR_SQE_INDEX 6'h03
`define MOSR_CAP_WINDOW 3'h3
`define MOSR_STATUS_WINDOW 3'h4
// ====================================================================
// capability bit positions
`define MOSR_CAP_TX_INT 1
`define MOSR_CAP_FX 2
`define MOSR_CAP_TP10 3
`define MOSR_CAP_EXT_PHY 6
`define MOSR_CAP_RESET 16'h0000
`define MOSR_NVM_CAP_WORD 6'h13
// ====================================================================
// control/status bit positions
`define MOSR_ST_KEEP_FCS 2
`define MOSR_ST_SQE_EN 3
`define MOSR_ST_GUARD 6
`define MOSR_ST_REQ_LINK 7
`define MOSR_CMD_TX_RESET 0
// ====================================================================
// timing
`define MOSR_CLK_MHZ 25
`define MOSR_JABBER_TIME_US 20000
`endif

// >>> hdl/mosr_pkg.sv
// types shared by the media capability and status bank
// assumes the constants header is compiled alongside
package mosr_pkg;
  // bus response code
  typedef logic [1:0] mosr_resp_t;
  // 16-bit register word
  typedef logic [15:0] mosr_word_t;
  // capability load sequencer
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_REQ = 2'b01,
    LD_DONE = 2'b10
  } mosr_load_t;
  localparam mosr_resp_t MOSR_OKAY = 2'b00;
  localparam mosr_resp_t MOSR_SLVERR = 2'b10;
endpackage

// >>> hdl/mosr_sync2.sv
// two-stage synchroniser for a group of independent pin levels
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/10ps
`default_nettype none
module mosr_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // first stage, read only by the second
  logic [W-1:0] meta;
  // ==================================================================
  // two flops in series, frozen with the clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/mosr_babble_timer.sv
// transmit watchdog: trips when sending runs unbroken too long
// assumes sending is a registered level on the same clock
`timescale 1ns/10ps
`default_nettype none
module mosr_babble_timer #(
  parameter int unsigned CYCLES = 500000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sending,
  input wire logic guard_on,
  input wire logic clear,
  output logic tripped
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES - 1);
  // unbroken sending length
  logic [CW-1:0] run;
  // limit reached while guarded
  wire timeout = sending & guard_on & (run == LIMIT);
  // ==================================================================
  // run counter restarts whenever sending pauses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= '0;
    end else if (ce) begin
      if (!sending || timeout) begin
        run <= '0;
      end else begin
        run <= run + CW'(1);
      end
    end
  end
  // ==================================================================
  // sticky trip, set wins over a simultaneous clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tripped <= 1'b0;
    end else if (ce) begin
      if (timeout) begin
        tripped <= 1'b1;
      end else if (clear) begin
        tripped <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/mosr_top.sv
// media capability and media control/status bank on axi4-lite
// assumes pins arrive asynchronously; mac and nvm share aclk
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mosr_regs.svh"
module mosr_top #(
  parameter int unsigned JABBER_CYCLES =
    `MOSR_JABBER_TIME_US * `MOSR_CLK_MHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output mosr_pkg::mosr_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output mosr_pkg::mosr_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // configuration nvm word fetch
  output logic nvm_req,
  output logic [5:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic [15:0] nvm_data,
  // mode from the mac configuration
  input wire logic mii_mode,
  input wire logic speed100,
  // transceiver pins
  input wire logic pin_collision,
  input wire logic pin_carrier,
  input wire logic pin_link_beat,
  input wire logic pin_link_monitor,
  input wire logic pin_rx_inverted,
  // mac side
  input wire logic mac_tx_request,
  input wire logic sqe_error_pulse,
  output logic tx_enable_out,
  output logic rx_keep_fcs_out,
  output logic polarity_fix_out,
  output logic tx_reset_pulse,
  output logic [7:0] sqe_error_counter
);
  import mosr_pkg::*;

  // ==================================================================
  // pin synchronisation
  logic [4:0] pins_sync;
  mosr_sync2 #(
    .W(5)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in({pin_rx_inverted, pin_link_monitor, pin_link_beat,
               pin_carrier, pin_collision}),
    .sync_out(pins_sync)
  );
  wire collision_live = pins_sync[0];
  wire carrier_live = pins_sync[1];
  wire link_beat_s = pins_sync[2];
  wire link_mon_s = pins_sync[3];
  wire rx_pair_inverted = pins_sync[4];

  // ==================================================================
  // register state
  logic [2:0] win_sel; // register window select
  mosr_word_t media_capability; // loaded capability word
  mosr_load_t load_state; // capability load sequencer
  logic keep_rx_fcs; // pass fcs to host
  logic sqe_count_enable; // sqe statistics gate
  logic babble_guard_on; // jabber guard
  logic require_link_pulse; // link beat gating
  logic babble_tripped; // jabber state

  // ==================================================================
  // bus decode
  wire wr_go = awvalid & awready & wvalid & wready;
  wire [5:0] wr_idx = awaddr[7:2];
  wire [5:0] rd_idx = araddr[7:2];
  wire wr_lane0 = wr_go & wstrb[0];
  wire in_cap_win = (win_sel == `MOSR_CAP_WINDOW);
  wire in_st_win = (win_sel == `MOSR_STATUS_WINDOW);
  wire wr_winsel = wr_lane0 & (wr_idx == `MOSR_WINSEL_INDEX);
  wire wr_cmd = wr_lane0 & (wr_idx == `MOSR_CMD_INDEX);
  // only window four lets the status word be written
  wire wr_status = wr_lane0 & in_st_win &
    (wr_idx == `MOSR_STATUS_INDEX);
  wire rd_map_win = (rd_idx == `MOSR_WINSEL_INDEX);
  wire rd_map_cmd = (rd_idx == `MOSR_CMD_INDEX);
  wire rd_map_sqe = (rd_idx == `MOSR_SQE_INDEX);
  wire rd_map_cap = (rd_idx == `MOSR_CAP_INDEX);
  wire rd_map_st = (rd_idx == `MOSR_STATUS_INDEX);
  wire wr_mapped = (wr_idx == `MOSR_WINSEL_INDEX) |
    (wr_idx == `MOSR_CMD_INDEX) | (wr_idx == `MOSR_SQE_INDEX) |
    (wr_idx == `MOSR_CAP_INDEX) | (wr_idx == `MOSR_STATUS_INDEX);
  wire rd_mapped = rd_map_win | rd_map_cmd | rd_map_sqe |
    rd_map_cap | rd_map_st;

  // ==================================================================
  // live link and transmit gating
  // link source by mode, forced on without gating or under mii
  wire link_up_live = mii_mode | ~require_link_pulse |
    (speed100 ? link_mon_s : link_beat_s);
  wire tx_allowed = ~babble_tripped &
    (~require_link_pulse | link_up_live);
  wire frame_sending_live = tx_enable_out;

  // ==================================================================
  // readback words, reserved bits zero
  wire mosr_word_t status_word = {
    1'b1, // attachment unit off
    1'b0, // coax power on
    1'b0,
    frame_sending_live,
    link_up_live,
    rx_pair_inverted,
    babble_tripped,
    1'b0,
    require_link_pulse,
    babble_guard_on,
    carrier_live,
    collision_live,
    sqe_count_enable,
    keep_rx_fcs,
    2'b00
  };
  wire mosr_word_t cap_vis = in_cap_win ? media_capability : 16'h0000;
  wire mosr_word_t st_vis = in_st_win ? status_word : 16'h0000;
  wire [31:0] rd_mux =
    rd_map_win ? {29'h0000000, win_sel} :
    rd_map_sqe ? {24'h000000, sqe_error_counter} :
    rd_map_cap ? {16'h0000, cap_vis} :
    rd_map_st ? {16'h0000, st_vis} :
    32'h00000000;

  // capability word from nvm: unsupported flags forced to zero,
  // internal tx flag dropped when an external phy is declared
  wire mosr_word_t cap_from_nvm = {
    9'h000,
    nvm_data[`MOSR_CAP_EXT_PHY],
    2'b00,
    nvm_data[`MOSR_CAP_TP10],
    nvm_data[`MOSR_CAP_FX],
    nvm_data[`MOSR_CAP_TX_INT] & ~nvm_data[`MOSR_CAP_EXT_PHY],
    1'b0
  };

  // ==================================================================
  // write address and data taken together, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else if (ce) begin
      awready <= awvalid & wvalid & ~awready & ~bvalid;
      wready <= awvalid & wvalid & ~wready & ~bvalid;
    end
  end

  // ==================================================================
  // write response held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= MOSR_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? MOSR_OKAY : MOSR_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==================================================================
  // read address taken one at a time, data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= MOSR_OKAY;
    end else if (ce) begin
      arready <= arvalid & ~arready & ~rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_mapped ? MOSR_OKAY : MOSR_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==================================================================
  // window select and transmit reset command pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_sel <= 3'h0;
      tx_reset_pulse <= 1'b0;
    end else if (ce) begin
      if (wr_winsel) begin
        win_sel <= wdata[2:0];
      end
      tx_reset_pulse <= wr_cmd & wdata[`MOSR_CMD_TX_RESET];
    end
  end

  // ==================================================================
  // writable control bits; other bits ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keep_rx_fcs <= 1'b0;
      sqe_count_enable <= 1'b0;
      babble_guard_on <= 1'b0;
      require_link_pulse <= 1'b0;
    end else if (ce && wr_status) begin
      keep_rx_fcs <= wdata[`MOSR_ST_KEEP_FCS];
      sqe_count_enable <= wdata[`MOSR_ST_SQE_EN];
      babble_guard_on <= wdata[`MOSR_ST_GUARD];
      require_link_pulse <= wdata[`MOSR_ST_REQ_LINK];
    end
  end

  // ==================================================================
  // capability load: cleared at reset, then one nvm fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_state <= LD_IDLE;
      media_capability <= `MOSR_CAP_RESET;
      nvm_req <= 1'b0;
      nvm_addr <= 6'h00;
    end else if (ce) begin
      case (load_state)
        LD_IDLE: begin
          nvm_req <= 1'b1;
          nvm_addr <= `MOSR_NVM_CAP_WORD;
          load_state <= LD_REQ;
        end
        LD_REQ: begin
          if (nvm_ack) begin
            media_capability <= cap_from_nvm;
            nvm_req <= 1'b0;
            load_state <= LD_DONE;
          end
        end
        LD_DONE: begin
          nvm_req <= 1'b0;
        end
        default: begin
          load_state <= LD_IDLE;
          nvm_req <= 1'b0;
        end
      endcase
    end
  end

  // ==================================================================
  // mac side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_enable_out <= 1'b0;
      rx_keep_fcs_out <= 1'b0;
      polarity_fix_out <= 1'b0;
    end else if (ce) begin
      tx_enable_out <= mac_tx_request & tx_allowed;
      rx_keep_fcs_out <= keep_rx_fcs;
      // twisted-pair polarity correction needs the guard
      polarity_fix_out <= babble_guard_on & rx_pair_inverted &
        ~mii_mode & ~speed100;
    end
  end

  // ==================================================================
  // sqe error statistics, wraps at full scale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sqe_error_counter <= 8'h00;
    end else if (ce && sqe_error_pulse && sqe_count_enable) begin
      sqe_error_counter <= sqe_error_counter + 8'h01;
    end
  end

  // ==================================================================
  // jabber watchdog, released by the transmit reset command
  mosr_babble_timer #(
    .CYCLES(JABBER_CYCLES)
  ) u_babble (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sending(tx_enable_out),
    .guard_on(babble_guard_on),
    .clear(tx_reset_pulse),
    .tripped(babble_tripped)
  );

  // ==================================================================
  // checks on the bank behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // response raised with one of the two legal codes
  sequence s_resp_held;
    bvalid && (bresp == MOSR_OKAY || bresp == MOSR_SLVERR);
  endsequence

  a_unsup_flags_zero: assert property (
    media_capability[0] == 1'b0 && media_capability[5:4] == 2'b00 &&
    media_capability[8] == 1'b0)
    else $error("unsupported media flag set");
  a_cap_tx_ext: assert property (
    media_capability[`MOSR_CAP_EXT_PHY] |->
    !media_capability[`MOSR_CAP_TX_INT])
    else $error("internal tx flag with external phy");
  a_cap_nvm_load: assert property (
    load_state == LD_REQ && nvm_ack |=>
    media_capability == $past(cap_from_nvm) && !nvm_req)
    else $error("capability not loaded from nvm word");
  a_status_fixed: assert property (
    status_word[15] && !status_word[14])
    else $error("fixed status bits wrong");
  a_link_forced: assert property (
    (!require_link_pulse || mii_mode) |-> link_up_live)
    else $error("link bit not forced on");
  a_tx_link_gate: assert property (
    tx_enable_out && $past(require_link_pulse) |->
    $past(link_up_live))
    else $error("transmit without link pulse");
  a_jabber_block: assert property (
    $past(babble_tripped) |-> !tx_enable_out)
    else $error("transmit while jabber tripped");
  a_jabber_sticky: assert property (
    babble_tripped && !tx_reset_pulse |=> babble_tripped)
    else $error("jabber flag dropped without reset");
  a_sqe_gated: assert property (
    !sqe_count_enable |=> $stable(sqe_error_counter))
    else $error("sqe counter moved while disabled");
  a_polarity_guard: assert property (
    polarity_fix_out |-> $past(babble_guard_on))
    else $error("polarity fixed without guard");
  a_write_resp: assert property (
    s_wr_taken |=> s_resp_held)
    else $error("write response missing");
endmodule
`default_nettype wire

// >>> dv/mosr_phy_model.sv
// far-side model: configuration memory word fetch and transceiver pins
// assumes the bench sets pin levels, the config word and the stall
`timescale 1ns/10ps
`default_nettype none
module mosr_phy_model (
  input wire logic aclk,
  input wire logic nvm_req,
  input wire logic [5:0] nvm_addr,
  input wire logic [15:0] cfg_word,
  input wire logic [7:0] stall,
  input wire logic [4:0] lvl,
  output logic nvm_ack,
  output logic [15:0] nvm_data,
  output logic [4:0] pins
);
  // ==================================================================
  // config memory
  int unsigned wait_cnt; // cycles spent stalling the fetch
  initial begin
    nvm_ack = 1'b0;
    nvm_data = 16'h5a5a;
    wait_cnt = 0;
  end
  // answer after the stall; data changes every cycle outside the ack
  always @(posedge aclk) begin
    if (nvm_req && !nvm_ack && wait_cnt >= stall) begin
      nvm_ack <= 1'b1;
      nvm_data <= (nvm_addr == 6'h13) ? cfg_word : 16'hdead;
      wait_cnt <= 0;
    end else begin
      nvm_ack <= 1'b0;
      nvm_data <= ~nvm_data;
      wait_cnt <= nvm_req ? wait_cnt + 1 : 0;
    end
  end
  // ==================================================================
  // pins follow the bench levels 3 ns later, off the clock edge
  assign #3 pins = lvl;
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the media capability and control/status bank
// assumes the far-side model answers the config fetch and drives pins
`timescale 1ns/10ps
`default_nettype none
`include "mosr_regs.svh"
module testbench;
  import mosr_pkg::*;
  // ==================================================================
  // addresses and signals
  localparam logic [7:0] A_WIN = {`MOSR_WINSEL_INDEX, 2'b00};
  localparam logic [7:0] A_CMD = {`MOSR_CMD_INDEX, 2'b00};
  localparam logic [7:0] A_SQE = {`MOSR_SQE_INDEX, 2'b00};
  localparam logic [7:0] A_CAP = {`MOSR_CAP_INDEX, 2'b00};
  localparam logic [7:0] A_ST = {`MOSR_STATUS_INDEX, 2'b00};
  localparam logic [7:0] A_BAD = 8'h3c; // unmapped word
  localparam int unsigned JAB = 16; // shortened watchdog span
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to check the freeze
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  mosr_resp_t bresp;
  logic bvalid;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  mosr_resp_t rresp;
  logic rvalid;
  logic nvm_req, nvm_ack;
  logic [5:0] nvm_addr;
  logic [15:0] nvm_data;
  logic [15:0] cfg_word = 16'h000f; // config word for the first load
  logic [7:0] stall = 8'h1e; // slow memory on the first load
  logic [4:0] lvl = 5'h00; // {inverted, monitor, beat, carrier, coll}
  logic [4:0] pins;
  logic mii_mode = 1'b0;
  logic speed100 = 1'b0;
  logic mac_tx_request = 1'b0;
  logic sqe_error_pulse = 1'b0;
  logic tx_enable_out, rx_keep_fcs_out, polarity_fix_out, tx_reset_pulse;
  logic [7:0] sqe_error_counter;
  int miscompares = 0;
  int checks = 0;
  int pulses = 0; // transmit reset pulses seen
  // clock and pulse counter
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (tx_reset_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  mosr_top #(.JABBER_CYCLES(JAB)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack),
    .nvm_data(nvm_data), .mii_mode(mii_mode), .speed100(speed100),
    .pin_collision(pins[0]), .pin_carrier(pins[1]),
    .pin_link_beat(pins[2]), .pin_link_monitor(pins[3]),
    .pin_rx_inverted(pins[4]), .mac_tx_request(mac_tx_request),
    .sqe_error_pulse(sqe_error_pulse), .tx_enable_out(tx_enable_out),
    .rx_keep_fcs_out(rx_keep_fcs_out),
    .polarity_fix_out(polarity_fix_out),
    .tx_reset_pulse(tx_reset_pulse),
    .sqe_error_counter(sqe_error_counter)
  );
  mosr_phy_model u_phy (
    .aclk(aclk), .nvm_req(nvm_req), .nvm_addr(nvm_addr),
    .cfg_word(cfg_word), .stall(stall), .lvl(lvl),
    .nvm_ack(nvm_ack), .nvm_data(nvm_data), .pins(pins)
  );
  // ==================================================================
  // shared tasks; each starts and ends just after a rising edge
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d,
                        output mosr_resp_t r);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // each channel released at the edge that takes it
    while (!(aw_ok && w_ok) && n < 50) begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    chk_val({31'h0, n < 100}, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    mosr_resp_t r;
    axi_wr(a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e,
                        input mosr_resp_t er = MOSR_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    chk_val({31'h0, n < 100}, 32'h1);
    chk_val(rdata, {16'h0000, e});
    chk_val({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic reset_dut();
    aresetn <= 1'b0;
    cyc(16);
    aresetn <= 1'b1;
    cyc(1);
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    while (nvm_req === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk_val({31'h0, nvm_req}, 32'h0);
    cyc(2);
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==================================================================
  // scenarios
  task automatic t_cap();
    cyc(2);
    chk_val({25'h0, nvm_req, nvm_addr}, 32'h53);
    wr(A_WIN, 16'h0003);
    rd_chk(A_CAP, 16'h0000);
    wait_load();
    rd_chk(A_CAP, 16'h000e);
    wr(A_CAP, 16'hffff);
    rd_chk(A_CAP, 16'h000e);
    rd_chk(A_ST, 16'h0000);
  endtask
  task automatic t_ctrl();
    mosr_resp_t r;
    wr(A_WIN, 16'h0004);
    rd_chk(A_ST, 16'h8800);
    wr(A_ST, 16'hffff);
    rd_chk(A_ST, 16'h80cc);
    chk_val({31'h0, rx_keep_fcs_out}, 32'h1);
    axi_wr(A_BAD, 16'hffff, r);
    chk_val({30'h0, r}, {30'h0, MOSR_SLVERR});
    rd_chk(A_BAD, 16'h0000, MOSR_SLVERR);
    wr(A_ST, 16'h00c0);
    lvl <= 5'b10111;
    cyc(4);
    rd_chk(A_ST, 16'h8cf0);
    chk_val({31'h0, polarity_fix_out}, 32'h1);
    speed100 <= 1'b1;
    cyc(4);
    rd_chk(A_ST, 16'h84f0);
    mii_mode <= 1'b1;
    cyc(4);
    rd_chk(A_ST, 16'h8cf0);
    chk_val({31'h0, polarity_fix_out}, 32'h0);
    mii_mode <= 1'b0;
    speed100 <= 1'b0;
    lvl <= 5'b00000;
    cyc(4);
  endtask
  task automatic t_tx();
    wr(A_ST, 16'h0080);
    mac_tx_request <= 1'b1;
    cyc(4);
    chk_val({31'h0, tx_enable_out}, 32'h0);
    lvl <= 5'b00100;
    cyc(5);
    chk_val({31'h0, tx_enable_out}, 32'h1);
    rd_chk(A_ST, 16'h9880);
    mac_tx_request <= 1'b0;
    cyc(2);
    chk_val({31'h0, tx_enable_out}, 32'h0);
    lvl <= 5'b00000;
  endtask
  task automatic t_jab();
    int p0;
    wr(A_ST, 16'h0040);
    p0 = pulses;
    mac_tx_request <= 1'b1;
    cyc(JAB + 8);
    chk_val({31'h0, tx_enable_out}, 32'h0);
    mac_tx_request <= 1'b0;
    cyc(2);
    rd_chk(A_ST, 16'h8a40);
    wr(A_CMD, 16'h0001);
    cyc(2);
    chk_val(pulses - p0, 32'h1);
    rd_chk(A_ST, 16'h8840);
  endtask
  task automatic t_sqe();
    wr(A_ST, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr(A_ST, 16'h0008);
      end
      sqe_error_pulse <= 1'b1;
      cyc(1);
      sqe_error_pulse <= 1'b0;
      cyc(1);
      if (i == 2) begin
        rd_chk(A_SQE, 16'h0000);
      end
    end
    chk_val({24'h0, sqe_error_counter}, 32'h3);
    rd_chk(A_SQE, 16'h0003);
    // a pulse while the clock enable is low must not count
    ce <= 1'b0;
    sqe_error_pulse <= 1'b1;
    cyc(2);
    ce <= 1'b1;
    sqe_error_pulse <= 1'b0;
    cyc(1);
    chk_val({24'h0, sqe_error_counter}, 32'h3);
  endtask
  task automatic t_rst();
    wr(A_ST, 16'h0004);
    cfg_word <= 16'hffff;
    stall <= 8'h00;
    reset_dut();
    cyc(2);
    chk_val({31'h0, rx_keep_fcs_out}, 32'h0);
    wait_load();
    wr(A_WIN, 16'h0003);
    rd_chk(A_CAP, 16'h004c);
    wr(A_WIN, 16'h0004);
    rd_chk(A_ST, 16'h8800);
  endtask
  // ==================================================================
  // main sequence and watchdog
  initial begin
    reset_dut();
    t_cap();
    t_ctrl();
    t_tx();
    t_jab();
    t_sqe();
    t_rst();
    conclude();
  end
  initial begin
    #(40 * 20000);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
